// [dv/float_status_exception_unit_tb_top.sv]
// Purpose: Self-checking bench for the status and exception unit
// Assumes: Zero-wait slave, hready tied to hreadyout
// Notes: Scenarios run in order; t_readonly judges state left by t_masked
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module float_status_exception_unit_tb_top;
  import fp_exc_pkg::*;
  logic mclk, rst_n, hsel, hwrite, start, hreadyout, hresp, irq_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lag;
  logic [7:0] irq_vector;
  fp_event_t op, ev;
  fp_result_t res, r;
  int fail_count, n_compared;
  localparam logic [4:0] XS [6] = '{5'h10, 5'h08, 5'h00, 5'h04, 5'h02, 5'h01};
  localparam logic [3:0] CS [6] = '{CODE_ILLEGAL_OP, CODE_DIV_ZERO, CODE_CONV, CODE_OVF,
    CODE_UNF, CODE_UNDEF_VAR};

  float_status_exception_unit float_status_exception_unit_inst (.mclk(mclk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ev(ev), .res(res), .irq_req(irq_req), .irq_vector(irq_vector));
  fp_datapath_model fp_datapath_model_inst (.mclk(mclk), .rst_n(rst_n), .start(start),
    .lag(lag), .op(op), .ev(ev));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ************************************************************
  // Bus and event helpers
  // ************************************************************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic fp_event_t mk(input logic [4:0] x, input logic c, input logic [15:0] a,
    input logic [63:0] v);
    fp_event_t e;
    e = '0;
    e.exc = x;
    e.is_conv = c;
    e.instr_addr = a;
    e.conv_value = v;
    e.exp_full = 10'h1a5;
    return e;
  endfunction

  task automatic fire(input fp_event_t e, input logic [3:0] l, input logic xirq);
    @(posedge mclk);
    op <= e;
    lag <= l;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    // Loop leaves on the edge that takes done; res is launched there
    do @(posedge mclk); while (ev.done !== 1'b1);
    #1;
    r = res;
    `CHK("res valid", 1'b1, r.valid)
    `CHK("irq early", 1'b0, irq_req)
    @(posedge mclk);
    #1;
    `CHK("irq", xirq, irq_req)
  endtask

  task automatic chk_regs(input logic [3:0] c, input logic [15:0] a);
    bus(1'b0, EXC_CODE_OFS, 32'h0);
    `CHK("code", {28'h0, c}, rd)
    bus(1'b0, EXC_ADDR_OFS, 32'h0);
    `CHK("address", {16'h0, a}, rd)
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'h0, rd)
    chk_regs(CODE_NONE, 16'h0);
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("vector", 8'ha4, irq_vector)
    `CHK("okay resp", 1'b0, hresp)
  endtask

  task automatic t_flags();
    fp_event_t e;
    e = mk(5'h00, 1'b0, 16'h0001, 64'h0);
    e.neg = 1'b1;
    e.carry = 1'b1;
    fire(e, 4'h0, 1'b0);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("neg flag", 4'h8, rd[3:0])
    e.neg = 1'b0;
    e.zero = 1'b1;
    fire(e, 4'h2, 1'b0);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("zero flag", 4'h4, rd[3:0])
    e = mk(5'h00, 1'b1, 16'h0002, 64'h5);
    e.carry = 1'b1;
    fire(e, 4'h1, 1'b0);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("carry flag", 4'h1, rd[3:0])
    chk_regs(CODE_NONE, 16'h0);
  endtask

  task automatic t_causes();
    logic [15:0] a;
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, STATUS_OFS, g ? 32'h8f40 : 32'h0f40);
      for (int i = 0; i < 6; i++) begin
        a = 16'h4000 + 16'(g * 16 + i);
        fire(mk(XS[i], i == 2, a, 64'h1_0000_0000), 4'(i), g == 0);
        if (i == 3) `CHK("ovf exponent", 8'ha5, r.exp_out)
        if (i == 2) `CHK("conv zero", 1'b1, r.force_zero)
        chk_regs(CS[i], a);
      end
    end
  endtask

  task automatic t_masked();
    fp_event_t e;
    bus(1'b1, STATUS_OFS, 32'h0);
    fire(mk(5'h08, 1'b0, 16'h0bad, 64'h0), 4'h0, 1'b1);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("div flags", 4'h0, rd[3:0])
    fire(mk(5'h04, 1'b0, 16'h1111, 64'h0), 4'h0, 1'b0);
    fire(mk(5'h02, 1'b0, 16'h2222, 64'h0), 4'h3, 1'b0);
    `CHK("unf zero", 1'b1, r.force_zero)
    `CHK("unf exponent", 8'h00, r.exp_out)
    // Failing conversion carries set flag inputs that must not land
    e = mk(5'h00, 1'b1, 16'h3333, 64'h8000);
    e.neg = 1'b1;
    e.zero = 1'b1;
    e.carry = 1'b1;
    fire(e, 4'h0, 1'b0);
    `CHK("short conv zero", 1'b1, r.force_zero)
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("flags kept", 4'h0, rd[3:0])
    fire(mk(5'h01, 1'b0, 16'h5555, 64'h0), 4'h2, 1'b0);
    chk_regs(CODE_DIV_ZERO, 16'h0bad);
    bus(1'b1, STATUS_OFS, 32'h0040);
    fire(mk(5'h00, 1'b1, 16'h4444, 64'h8000), 4'h0, 1'b0);
    `CHK("long conv ok", 1'b0, r.force_zero)
    chk_regs(CODE_DIV_ZERO, 16'h0bad);
  endtask

  task automatic t_readonly();
    bus(1'b1, EXC_CODE_OFS, 32'hffff_ffff);
    bus(1'b1, EXC_ADDR_OFS, 32'hffff_ffff);
    chk_regs(CODE_DIV_ZERO, 16'h0bad);
    bus(1'b1, STATUS_OFS, 32'hffff_ffff);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK("status bits", {16'h0, STATUS_SW_MASK}, rd & 32'hffff_fff0)
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous span; whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    {rst_n, hsel, hwrite, start, htrans, haddr, hwdata, lag, op} = '0;
    hsize = 3'b010;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_causes();
    t_masked();
    t_readonly();
    print_verdict();
  end
endmodule

// [dv/fp_datapath_model.sv]
// Purpose: Floating-point datapath stand-in that hands finished ops to the unit
// Assumes: Same clock and reset as the unit
// Notes: Fields toggle between ops so stale values are never mistaken for live ones
`timescale 1ns/1ns
module fp_datapath_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] lag,
  input wire fp_exc_pkg::fp_event_t op,
  output fp_exc_pkg::fp_event_t ev
);
  import fp_exc_pkg::*;
  fp_event_t held_q, ev_d;
  logic [3:0] cnt_q;
  logic busy_q;
  // Idle fields invert every cycle; only done qualifies them
  always_comb begin
    ev_d = ~ev;
    ev_d.done = 1'b0;
    if (!start && busy_q && cnt_q == 4'h0) begin
      ev_d = held_q;
      ev_d.done = 1'b1;
    end
  end
  // Lag gives slow completion as well as prompt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
      held_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      ev <= ev_d;
      if (start) begin
        held_q <= op;
        cnt_q <= lag;
        busy_q <= 1'b1;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule

// [src/float_status_exception_unit.sv]
// Purpose: Condition flags, exception enables, exception code and address capture
// Assumes: Datapath pulses ev.done for one cycle per finished floating-point op
// Notes: Zero-wait AHB-Lite slave; interrupt request follows the capture by one cycle
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module float_status_exception_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire fp_exc_pkg::fp_event_t ev,
  output fp_exc_pkg::fp_result_t res,
  output logic irq_req,
  output logic [7:0] irq_vector
);
  import fp_exc_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  logic [15:0] status_q, status_d;
  logic [3:0] code_q, code_d;
  logic [15:0] addr_q, addr_d;
  fp_result_t res_q, res_d;
  logic pend_q, pend_d;
  logic irq_q, irq_d;
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_DEC_W-1:0] wr_ofs_q, wr_ofs_d;
  logic [31:0] rdata_q, rdata_d;

  // ************************************************************
  // Event decode
  // ************************************************************
  logic conv_fits, conv_fail, any_exc, capture, raise;
  logic [3:0] cause;

  always_comb begin
    // Sign-extension check: upper bits must all copy the sign bit
    if (status_q[BIT_INT_LONG]) begin
      conv_fits = (ev.conv_value[63:LONG_INT_W-1] == '0) ||
                  (ev.conv_value[63:LONG_INT_W-1] == '1);
    end else begin
      conv_fits = (ev.conv_value[63:SHORT_INT_W-1] == '0) ||
                  (ev.conv_value[63:SHORT_INT_W-1] == '1);
    end
    conv_fail = ev.is_conv && !conv_fits;
    any_exc = ev.exc.illegal_op || ev.exc.div_zero || conv_fail ||
              ev.exc.overflow || ev.exc.underflow || ev.exc.undef_var;
    // Fixed priority when several causes coincide; lowest code wins
    cause = CODE_NONE;
    capture = 1'b0;
    if (ev.exc.illegal_op) begin
      cause = CODE_ILLEGAL_OP;
      capture = 1'b1;
    end else if (ev.exc.div_zero) begin
      cause = CODE_DIV_ZERO;
      capture = 1'b1;
    end else if (conv_fail) begin
      cause = CODE_CONV;
      capture = status_q[BIT_CONV_IE];
    end else if (ev.exc.overflow) begin
      cause = CODE_OVF;
      capture = status_q[BIT_OVF_IE];
    end else if (ev.exc.underflow) begin
      cause = CODE_UNF;
      capture = status_q[BIT_UNF_IE];
    end else if (ev.exc.undef_var) begin
      cause = CODE_UNDEF_VAR;
      capture = status_q[BIT_UNDEF_IE];
    end
    capture = capture && ev.done && any_exc;
    raise = capture && !status_q[BIT_GLOBAL_DIS];
  end

  // ************************************************************
  // Flags, capture, result shaping, interrupt
  // ************************************************************
  always_comb begin
    status_d = status_q;
    code_d = code_q;
    addr_d = addr_q;
    res_d = '0;
    pend_d = raise;
    irq_d = pend_q;
    if (ev.done && !conv_fail) begin
      status_d[BIT_NEG] = ev.neg;
      status_d[BIT_ZERO] = ev.zero;
      status_d[BIT_CARRY] = ev.is_conv && ev.carry;
      status_d[BIT_OVF] = ev.exc.overflow;
    end
    if (capture) begin
      code_d = cause;
      addr_d = ev.instr_addr;
    end
    if (ev.done) begin
      res_d.valid = 1'b1;
      // Low eight bits only: an overflowed exponent reads 256 too small
      res_d.exp_out = ev.exp_full[7:0];
      if (conv_fail) begin
        res_d.force_zero = 1'b1;
      end else if (ev.exc.underflow && !status_q[BIT_UNF_IE]) begin
        res_d.force_zero = 1'b1;
        res_d.exp_out = '0;
      end
    end
    // Software reaches only enables and modes; hardware-written bits kept
    if (wr_pend_q && wr_ofs_q == STATUS_OFS) begin
      status_d = (status_d & ~STATUS_SW_MASK) | (hwdata[15:0] & STATUS_SW_MASK);
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic addr_ph;

  always_comb begin
    addr_ph = hsel && htrans[1] && hready;
    wr_pend_d = addr_ph && hwrite;
    wr_ofs_d = addr_ph ? haddr[ADDR_DEC_W-1:0] : wr_ofs_q;
    rdata_d = rdata_q;
    if (addr_ph && !hwrite) begin
      if (haddr[ADDR_DEC_W-1:0] == STATUS_OFS) begin
        rdata_d = {16'h0000, status_q};
      end else if (haddr[ADDR_DEC_W-1:0] == EXC_CODE_OFS) begin
        rdata_d = {28'h0000000, code_q};
      end else if (haddr[ADDR_DEC_W-1:0] == EXC_ADDR_OFS) begin
        rdata_d = {16'h0000, addr_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    // Writes to code and address offsets fall through with no effect
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
      code_q <= CODE_NONE;
      addr_q <= 16'h0000;
      res_q <= '0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= '0;
      rdata_q <= 32'h00000000;
    end else begin
      status_q <= status_d;
      code_q <= code_d;
      addr_q <= addr_d;
      res_q <= res_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
      wr_pend_q <= wr_pend_d;
      wr_ofs_q <= wr_ofs_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign res = res_q;
  assign irq_req = irq_q;
  assign irq_vector = FP_VECTOR;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic only_ovf, only_unf, only_undef;
  assign only_ovf = ev.exc.overflow && !ev.exc.illegal_op && !ev.exc.div_zero && !conv_fail;
  assign only_unf = ev.exc.underflow && !ev.exc.overflow && !ev.exc.illegal_op &&
                    !ev.exc.div_zero && !conv_fail;
  assign only_undef = ev.exc.undef_var && !ev.exc.underflow && !ev.exc.overflow &&
                      !ev.exc.illegal_op && !ev.exc.div_zero && !conv_fail;

  property p_neg_flag;
    ev.done && !conv_fail && !wr_pend_q |=> status_q[BIT_NEG] == $past(ev.neg);
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

  property p_zero_flag;
    ev.done && !conv_fail && !wr_pend_q |=> status_q[BIT_ZERO] == $past(ev.zero);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_carry_conv;
    ev.done && !ev.is_conv |=> !status_q[BIT_CARRY];
  endproperty
  a_carry_conv: assert property (p_carry_conv) else $error("carry outside conversion");

  property p_ovf_irq;
    ev.done && only_ovf && status_q[BIT_OVF_IE] && !status_q[BIT_GLOBAL_DIS]
      // A back-to-back op may still have its own pulse standing one cycle on
      |=> irq_req == $past(pend_q) ##1 irq_req;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

  property p_ovf_exp;
    ev.done && only_ovf && status_q[BIT_OVF_IE] && ev.exp_full >= EXP_WRAP
      |=> (10'(res.exp_out) + EXP_WRAP) == $past(ev.exp_full);
  endproperty
  a_ovf_exp: assert property (p_ovf_exp) else $error("overflow exponent offset wrong");

  property p_ovf_masked;
    ev.done && only_ovf && !status_q[BIT_OVF_IE] && !ev.exc.undef_var
      |=> $stable(code_q) ##1 !irq_req;
  endproperty
  a_ovf_masked: assert property (p_ovf_masked) else $error("masked overflow acted");

  property p_unf_zero;
    ev.done && only_unf && !status_q[BIT_UNF_IE] |=> res.force_zero && res.exp_out == 8'h00;
  endproperty
  a_unf_zero: assert property (p_unf_zero) else $error("masked underflow not zero");

  property p_conv_fail;
    ev.done && conv_fail && !wr_pend_q |=> res.force_zero && $stable(status_q);
  endproperty
  a_conv_fail: assert property (p_conv_fail) else $error("conversion failure handling");

  property p_div_code;
    ev.done && ev.exc.div_zero && !ev.exc.illegal_op
      |=> code_q == CODE_DIV_ZERO && addr_q == $past(ev.instr_addr);
  endproperty
  a_div_code: assert property (p_div_code) else $error("divide by zero not captured");

  property p_no_exc_stable;
    !capture |=> $stable(code_q) && $stable(addr_q);
  endproperty
  a_no_exc_stable: assert property (p_no_exc_stable) else $error("code changed w/o cause");

  property p_fid_capture;
    ev.done && ev.exc.illegal_op && status_q[BIT_GLOBAL_DIS]
      |=> code_q == CODE_ILLEGAL_OP ##1 !irq_req;
  endproperty
  a_fid_capture: assert property (p_fid_capture) else $error("global disable blocked capture");

  property p_illegal_code;
    ev.done && ev.exc.illegal_op
      |=> code_q == CODE_ILLEGAL_OP && addr_q == $past(ev.instr_addr);
  endproperty
  a_illegal_code: assert property (p_illegal_code) else $error("illegal op capture");

  property p_ovf_capture;
    ev.done && only_ovf && status_q[BIT_OVF_IE]
      |=> code_q == CODE_OVF && addr_q == $past(ev.instr_addr);
  endproperty
  a_ovf_capture: assert property (p_ovf_capture) else $error("overflow code wrong");

  property p_unf_capture;
    ev.done && only_unf && status_q[BIT_UNF_IE]
      |=> code_q == CODE_UNF && addr_q == $past(ev.instr_addr);
  endproperty
  a_unf_capture: assert property (p_unf_capture) else $error("underflow address");

  property p_conv_irq;
    ev.done && conv_fail && !ev.exc.illegal_op && !ev.exc.div_zero &&
      status_q[BIT_CONV_IE] && !status_q[BIT_GLOBAL_DIS]
      |=> code_q == CODE_CONV ##1 irq_req;
  endproperty
  a_conv_irq: assert property (p_conv_irq) else $error("conversion interrupt");

  property p_conv_masked;
    ev.done && conv_fail && !ev.exc.illegal_op && !ev.exc.div_zero && !status_q[BIT_CONV_IE]
      |=> $stable(code_q) && $stable(addr_q) ##1 !irq_req;
  endproperty
  a_conv_masked: assert property (p_conv_masked) else $error("masked conversion");

  property p_undef_masked;
    ev.done && only_undef && !status_q[BIT_UNDEF_IE]
      |=> $stable(code_q) && $stable(addr_q) ##1 !irq_req;
  endproperty
  a_undef_masked: assert property (p_undef_masked) else $error("masked undef var");

  property p_unf_masked;
    ev.done && only_unf && !status_q[BIT_UNF_IE]
      |=> $stable(code_q) && $stable(addr_q) ##1 !irq_req;
  endproperty
  a_unf_masked: assert property (p_unf_masked) else $error("masked underflow acted");

  property p_short_fail;
    ev.done && ev.is_conv && !status_q[BIT_INT_LONG] &&
      ev.conv_value[63:SHORT_INT_W-1] != '0 && ev.conv_value[63:SHORT_INT_W-1] != '1
      |=> res.force_zero;
  endproperty
  a_short_fail: assert property (p_short_fail) else $error("short conversion fit");

  property p_long_fits;
    ev.done && ev.is_conv && status_q[BIT_INT_LONG] && ev.exc == '0 &&
      ev.conv_value[63:LONG_INT_W-1] == '0 |=> !res.force_zero;
  endproperty
  a_long_fits: assert property (p_long_fits) else $error("long conversion fit");

  // Every pulse traces back to an unblocked capture two cycles before
  property p_irq_cause;
    irq_req |-> $past(capture, 2) && !$past(status_q[BIT_GLOBAL_DIS], 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without capture");

  property p_vector;
    irq_req |-> irq_vector == FP_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("interrupt vector wrong");

  property p_sw_readonly;
    wr_pend_q && !capture |=> $stable(code_q) && $stable(addr_q);
  endproperty
  a_sw_readonly: assert property (p_sw_readonly) else $error("software reached code");

  c_ovf_irq: cover property (ev.done && only_ovf && status_q[BIT_OVF_IE] ##2 irq_req);
  c_conv_fail: cover property (ev.done && conv_fail ##1 res.force_zero);
  c_fid_div: cover property (ev.done && ev.exc.div_zero && status_q[BIT_GLOBAL_DIS]);
  c_long_mode: cover property (ev.done && ev.is_conv && status_q[BIT_INT_LONG]);
  c_undef_masked: cover property (ev.done && only_undef && !status_q[BIT_UNDEF_IE]);

endmodule

// [src/fp_exc_pkg.sv]
// Purpose: Shared constants and types for the floating-point status and exception unit
// Assumes: One processor clock; datapath events arrive on that clock
// Notes: Register map is word aligned on an AHB-Lite slave
package fp_exc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] EXC_CODE_OFS = 8'h04;
  localparam logic [7:0] EXC_ADDR_OFS = 8'h08;
  localparam int ADDR_DEC_W = 8;

  // ************************************************************
  // Status word bit positions and reset
  // ************************************************************
  localparam int BIT_CARRY = 0;
  localparam int BIT_OVF = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_NEG = 3;
  localparam int BIT_INT_LONG = 6;
  localparam int BIT_CONV_IE = 8;
  localparam int BIT_OVF_IE = 9;
  localparam int BIT_UNF_IE = 10;
  // Undefined-variable enable sits beside the other three enables
  localparam int BIT_UNDEF_IE = 11;
  localparam int BIT_GLOBAL_DIS = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_SW_MASK = 16'h8f40;

  // ************************************************************
  // Exception codes, vector, integer widths
  // ************************************************************
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_ILLEGAL_OP = 4'h2;
  localparam logic [3:0] CODE_DIV_ZERO = 4'h4;
  localparam logic [3:0] CODE_CONV = 4'h6;
  localparam logic [3:0] CODE_OVF = 4'h8;
  localparam logic [3:0] CODE_UNF = 4'ha;
  localparam logic [3:0] CODE_UNDEF_VAR = 4'hc;
  localparam logic [7:0] FP_VECTOR = 8'ha4;
  localparam logic [9:0] EXP_WRAP = 10'h100;
  localparam int SHORT_INT_W = 16;
  localparam int LONG_INT_W = 32;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic illegal_op;
    logic div_zero;
    logic overflow;
    logic underflow;
    logic undef_var;
  } exc_in_t;

  typedef struct packed {
    logic done;
    logic neg;
    logic zero;
    logic carry;
    logic is_conv;
    exc_in_t exc;
    logic [15:0] instr_addr;
    logic [9:0] exp_full;
    logic [63:0] conv_value;
  } fp_event_t;

  typedef struct packed {
    logic valid;
    logic force_zero;
    logic [7:0] exp_out;
  } fp_result_t;

endpackage
